//--- apt_cpu_model.sv
`timescale 1ns/100ps

module apt_cpu_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic stop_clock_request_n,
  input  wire logic halt_cmd,
  input  wire logic slow,
  output logic      halt_cycle,
  output logic      stop_grant_cycle
);
  logic [2:0] dly_ff;
  logic       halt_ff;
  logic       sg_ff;

  assign halt_cycle       = halt_ff;
  assign stop_grant_cycle = sg_ff;

  // Grant comes late in slow mode; held while the request stays low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_ff  <= 3'h0;
      halt_ff <= 1'b0;
      sg_ff   <= 1'b0;
    end else begin
      halt_ff <= halt_cmd;
      dly_ff  <= stop_clock_request_n ? 3'h0 : dly_ff + {2'h0, dly_ff != 3'h7};
      sg_ff   <= !stop_clock_request_n && dly_ff >= (slow ? 3'h6 : 3'h1);
    end
  end
endmodule : apt_cpu_model

//--- apt_defines.svh
`ifndef APT_DEFINES_SVH
`define APT_DEFINES_SVH

// Register byte offsets
`define APT_OFF_CTRL    8'h00
`define APT_OFF_LVL2    8'h04
`define APT_OFF_LVL3    8'h08
`define APT_OFF_STATUS  8'h0C
`define APT_OFF_WAKE    8'h10
`define APT_OFF_THR     8'h14

// Control register fields
`define APT_CTRL_SLPEN   0
`define APT_CTRL_TYP_LSB 1
`define APT_CTRL_TYP_MSB 3
`define APT_CTRL_THREN   4
`define APT_CTRL_CPU_SLEEP_REQUEST  5
`define APT_CTRL_MOBILE  6

// Status register fields
`define APT_STAT_STOP_CLOCK_REQUEST  4
`define APT_STAT_CSTOP   5
`define APT_STAT_CSLP    6
`define APT_STAT_BOOT    8

// Sleep type codes
`define APT_SLP_S1 3'h1
`define APT_SLP_S3 3'h3
`define APT_SLP_S4 3'h4
`define APT_SLP_S5 3'h5

// Reset values
`define APT_CTRL_RST 8'h00
`define APT_WAKE_RST 16'hFFFF
`define APT_THR_RST  16'h4010

`endif

//--- apt_pkg.sv
package apt_pkg;

  typedef enum logic [3:0] {
    ST_MOFF,
    ST_C0,
    ST_C1,
    ST_C2,
    ST_C3,
    ST_S1,
    ST_S3,
    ST_S4,
    ST_S5
  } apt_state_e;

  typedef struct packed {
    logic       halt;
    logic       sgnt;
    logic [7:0] brk;
    logic       pbo;
    logic       pfail;
    logic       pgood;
  } apt_pins_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } apt_ahb_ap_s;

endpackage : apt_pkg

//--- apt_throttle.sv
`timescale 1ns/100ps

module apt_throttle
  import apt_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       enable,
  input  wire logic [7:0] period,
  input  wire logic [7:0] duty,
  output logic            active
);

  logic [7:0] cnt_ff;
  logic       active_ff;
  wire        wrap     = (cnt_ff + 8'h01) >= period;
  wire  [7:0] nxt_cnt  = (!enable || wrap) ? 8'h00 : cnt_ff + 8'h01;
  wire        nxt_act  = enable && (cnt_ff < duty);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff    <= 8'h00;
      active_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      active_ff <= nxt_act;
    end
  end

  assign active = active_ff;

endmodule : apt_throttle

//--- apt_tracker.sv
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`include "apt_defines.svh"
// Functional notes
// - Halt cycle while fully on moves to auto-halt; snooping continues.
// - Level-two register read while fully on moves to stop-grant.
// - Level-three register read while fully on moves to stop-clock, mobile only.
// - Sleep-enable write while fully on enters state chosen by sleep-type.
// - Stop-grant drives the stop-clock request active to the processor.
// - Stop-grant entered from auto-halt returns to auto-halt on release.
// - In stop-clock, after stop-grant cycle, assert the CPU-clock-stop output.
// - Enabled break event from C1, C2, C3, S1, S3, S4 returns to full-on.
// - Fully on, stop-clock request may be throttled periodically.
// - Desktop S1 optionally asserts CPU-sleep on top of stop-grant.
// - Mobile S1 stops all clocks but the real-time clock; memory holds context.
// - Suspend-to-RAM keeps memory in refresh; all other clocks off.
// - Suspend-to-disk looks like soft-off but wakes on the sleep-state wake mask, not the soft-off one.
// - Waking from soft-off always flags a full boot.
// - Mechanical-off takes no wake; power return reboots or waits in soft-off.

module apt_tracker
  import apt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        halt_cycle,
  input  wire logic        stop_grant_cycle,
  input  wire logic [7:0]  break_event,
  input  wire logic        power_button_override,
  input  wire logic        power_fail,
  input  wire logic        power_good,
  output logic             stop_clock_request_n,
  output logic             cpu_clock_stop_n,
  output logic             cpu_sleep_request_n,
  output logic             clocks_run,
  output logic             mem_self_refresh,
  output logic             main_power_on,
  output logic             boot_required
);

  apt_state_e  st_ff, nxt_st;
  apt_pins_s   sync1_ff, sync2_ff, pin;
  apt_ahb_ap_s ap_ff, nxt_ap;
  logic [7:0]  ctrl_ff;
  logic [15:0] wake_ff;
  logic [15:0] thr_ff;
  logic [31:0] hrdata_ff;
  logic        from_c1_ff, nxt_from_c1;
  logic        prev_soff_ff;
  logic        boot_ff;
  logic        stop_clock_request_ff, cstop_ff, cslp_ff;
  logic        clkrun_ff, sref_ff, pwr_ff;
  logic        thr_active;

  function automatic apt_state_e slp_state(input logic [2:0] typ);
    case (typ)
      `APT_SLP_S1: slp_state = ST_S1;
      `APT_SLP_S3: slp_state = ST_S3;
      `APT_SLP_S4: slp_state = ST_S4;
      `APT_SLP_S5: slp_state = ST_S5;
      default:     slp_state = ST_C0;
    endcase
  endfunction : slp_state

  // Pin synchronisers
  assign pin = sync2_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {halt_cycle, stop_grant_cycle, break_event,
                   power_button_override, power_fail, power_good};
      sync2_ff <= sync1_ff;
    end
  end

  // AHB-Lite decode
  wire        ap_take  = hsel && hready && htrans[1];
  wire        rd_take  = ap_take && !hwrite;
  wire [7:0]  ap_addr  = haddr[7:0];
  wire        lvl2_hit = rd_take && (ap_addr == `APT_OFF_LVL2);
  wire        lvl3_hit = rd_take && (ap_addr == `APT_OFF_LVL3);
  wire        wr_dp    = ap_ff.valid && ap_ff.write;
  wire        wr_ctrl  = wr_dp && (ap_ff.addr == `APT_OFF_CTRL);
  wire        wr_rel   = wr_dp && (ap_ff.addr == `APT_OFF_LVL2);
  wire        wr_stat  = wr_dp && (ap_ff.addr == `APT_OFF_STATUS);
  wire        wr_wake  = wr_dp && (ap_ff.addr == `APT_OFF_WAKE);
  wire        wr_thr   = wr_dp && (ap_ff.addr == `APT_OFF_THR);
  wire        slp_go   = wr_ctrl && hwdata[`APT_CTRL_SLPEN];
  wire [2:0]  sleep_type_field  = hwdata[`APT_CTRL_TYP_MSB:`APT_CTRL_TYP_LSB];
  wire        mobile   = ctrl_ff[`APT_CTRL_MOBILE];
  wire        cpu_sleep_request_en = ctrl_ff[`APT_CTRL_CPU_SLEEP_REQUEST];
  wire        thr_en   = ctrl_ff[`APT_CTRL_THREN];
  wire [31:0] ctrl_rd  = {24'h000000, ctrl_ff};
  wire [31:0] stat_rd  = {23'h000000, boot_ff, 1'b0, cslp_ff, cstop_ff,
                          stop_clock_request_ff, st_ff};
  wire [31:0] rd_val   =
    (ap_addr == `APT_OFF_CTRL)   ? ctrl_rd :
    (ap_addr == `APT_OFF_STATUS) ? stat_rd :
    (ap_addr == `APT_OFF_WAKE)   ? {16'h0000, wake_ff} :
    (ap_addr == `APT_OFF_THR)    ? {16'h0000, thr_ff} : 32'h00000000;

  assign nxt_ap = '{valid: ap_take, write: hwrite, addr: ap_addr};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_ff     <= '0;
      hrdata_ff <= 32'h00000000;
    end else begin
      ap_ff     <= nxt_ap;
      hrdata_ff <= rd_take ? rd_val : hrdata_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `APT_CTRL_RST;
      wake_ff <= `APT_WAKE_RST;
      thr_ff  <= `APT_THR_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= {1'b0, hwdata[6:1], 1'b0};
      if (wr_wake) wake_ff <= hwdata[15:0];
      if (wr_thr)  thr_ff  <= hwdata[15:0];
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Break events
  wire brk_any  = |(pin.brk & wake_ff[7:0]);
  wire brk_soff = |(pin.brk & wake_ff[15:8]);

  apt_throttle u_thr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (thr_en && (st_ff == ST_C0)),
    .period  (thr_ff[15:8]),
    .duty    (thr_ff[7:0]),
    .active  (thr_active)
  );

  // Platform state machine
  always_comb begin
    nxt_st      = st_ff;
    nxt_from_c1 = from_c1_ff;
    if (pin.pfail) begin
      nxt_st = ST_MOFF;
    end else begin
      case (st_ff)
        ST_MOFF: begin
          if (pin.pgood) nxt_st = prev_soff_ff ? ST_S5 : ST_C0;
        end
        ST_C0: begin
          if (pin.pbo) nxt_st = ST_S5;
          else if (slp_go) nxt_st = slp_state(sleep_type_field);
          else if (lvl3_hit && mobile) nxt_st = ST_C3;
          else if (lvl2_hit) begin
            nxt_st      = ST_C2;
            nxt_from_c1 = 1'b0;
          end else if (pin.halt) nxt_st = ST_C1;
        end
        ST_C1: begin
          if (pin.pbo) nxt_st = ST_S5;
          else if (brk_any) nxt_st = ST_C0;
          else if (lvl2_hit) begin
            nxt_st      = ST_C2;
            nxt_from_c1 = 1'b1;
          end
        end
        ST_C2: begin
          if (pin.pbo) nxt_st = ST_S5;
          else if (brk_any) nxt_st = ST_C0;
          else if (wr_rel) nxt_st = from_c1_ff ? ST_C1 : ST_C0;
        end
        ST_C3, ST_S1, ST_S3, ST_S4: begin
          if (pin.pbo) nxt_st = ST_S5;
          else if (brk_any) nxt_st = ST_C0;
        end
        ST_S5: begin
          if (brk_soff) nxt_st = ST_C0;
        end
        default: nxt_st = ST_MOFF;
      endcase
    end
  end

  // Output and flag next values
  wire stop_state = (nxt_st == ST_C2) || (nxt_st == ST_C3) || (nxt_st == ST_S1);
  wire nxt_stop_clock_request = stop_state || ((nxt_st == ST_C0) && thr_active);
  wire sg_seen    = cstop_ff || pin.sgnt;
  wire nxt_cstop  = ((nxt_st == ST_C3) || ((nxt_st == ST_S1) && mobile)) && sg_seen;
  wire nxt_cslp   = (nxt_st == ST_S1) && !mobile && cpu_sleep_request_en;
  wire deep_off   = (nxt_st == ST_S3) || (nxt_st == ST_S4) ||
                    (nxt_st == ST_S5) || (nxt_st == ST_MOFF);
  wire mob_s1     = (nxt_st == ST_S1) && mobile;
  wire nxt_clkrun = !(mob_s1 || deep_off);
  wire nxt_sref   = mob_s1 || (nxt_st == ST_S3);
  wire nxt_pwr    = !((nxt_st == ST_S4) || (nxt_st == ST_S5) || (nxt_st == ST_MOFF));
  wire boot_set   = (nxt_st == ST_C0) && ((st_ff == ST_S5) || (st_ff == ST_MOFF));
  wire boot_clr   = wr_stat && hwdata[`APT_STAT_BOOT];
  wire nxt_boot   = boot_set || (boot_ff && !boot_clr);
  wire g3_entry   = (nxt_st == ST_MOFF) && (st_ff != ST_MOFF);
  wire nxt_prev   = g3_entry ? (st_ff == ST_S5) : prev_soff_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff        <= ST_MOFF;
      from_c1_ff   <= 1'b0;
      prev_soff_ff <= 1'b0;
      boot_ff      <= 1'b0;
      stop_clock_request_ff    <= 1'b0;
      cstop_ff     <= 1'b0;
      cslp_ff      <= 1'b0;
      clkrun_ff    <= 1'b0;
      sref_ff      <= 1'b0;
      pwr_ff       <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      from_c1_ff   <= nxt_from_c1;
      prev_soff_ff <= nxt_prev;
      boot_ff      <= nxt_boot;
      stop_clock_request_ff    <= nxt_stop_clock_request;
      cstop_ff     <= nxt_cstop;
      cslp_ff      <= nxt_cslp;
      clkrun_ff    <= nxt_clkrun;
      sref_ff      <= nxt_sref;
      pwr_ff       <= nxt_pwr;
    end
  end

  assign stop_clock_request_n = !stop_clock_request_ff;
  assign cpu_clock_stop_n     = !cstop_ff;
  assign cpu_sleep_request_n  = !cslp_ff;
  assign clocks_run           = clkrun_ff;
  assign mem_self_refresh     = sref_ff;
  assign main_power_on        = pwr_ff;
  assign boot_required        = boot_ff;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire c0_quiet = (st_ff == ST_C0) && !pin.pfail && !pin.pbo && !slp_go;

  property p_halt;
    c0_quiet && !lvl2_hit && !lvl3_hit && pin.halt |=> st_ff == ST_C1;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not enter C1");

  property p_lvl2;
    c0_quiet && lvl2_hit && !(lvl3_hit && mobile) |=> st_ff == ST_C2 ##0 !from_c1_ff;
  endproperty
  a_lvl2: assert property (p_lvl2) else $error("lvl2 read did not enter C2");

  property p_lvl3;
    c0_quiet && lvl3_hit |=> (st_ff == ST_C3) == $past(mobile);
  endproperty
  a_lvl3: assert property (p_lvl3) else $error("lvl3 read mishandled");

  property p_sleep;
    (st_ff == ST_C0) && !pin.pfail && !pin.pbo && slp_go |=> st_ff == slp_state($past(sleep_type_field));
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep enable wrong state");

  property p_stop_clock_request;
    (st_ff == ST_C2) || (st_ff == ST_C3) |-> !stop_clock_request_n;
  endproperty
  a_stop_clock_request: assert property (p_stop_clock_request) else $error("stop clock not active");

  property p_back_c1;
    (st_ff == ST_C2) && from_c1_ff && wr_rel && !brk_any && !pin.pbo && !pin.pfail
      |=> st_ff == ST_C1 ##1 (stop_clock_request_n || st_ff != ST_C1);
  endproperty
  a_back_c1: assert property (p_back_c1) else $error("release did not return to C1");

  property p_cstop;
    (st_ff == ST_C3) && pin.sgnt && !pin.pfail && !brk_any && !pin.pbo |=> !cpu_clock_stop_n;
  endproperty
  a_cstop: assert property (p_cstop) else $error("cpu clock stop missing");

  property p_break;
    (st_ff inside {ST_C1, ST_C2, ST_C3, ST_S1, ST_S3, ST_S4}) && brk_any
      && !pin.pfail && !pin.pbo |=> st_ff == ST_C0;
  endproperty
  a_break: assert property (p_break) else $error("break event ignored");

  property p_mob_s1;
    (st_ff == ST_S1) && $past(st_ff == ST_S1) && $past(mobile) |-> !clocks_run && mem_self_refresh;
  endproperty
  a_mob_s1: assert property (p_mob_s1) else $error("mobile S1 clocks running");

  property p_soff_boot;
    (st_ff == ST_S5) ##1 (st_ff == ST_C0) |-> boot_required;
  endproperty
  a_soff_boot: assert property (p_soff_boot) else $error("boot flag not set");

  property p_moff_hold;
    (st_ff == ST_MOFF) && !pin.pgood |=> st_ff == ST_MOFF;
  endproperty
  a_moff_hold: assert property (p_moff_hold) else $error("left G3 without power");

  property p_pfail;
    pin.pfail |=> st_ff == ST_MOFF && !main_power_on;
  endproperty
  a_pfail: assert property (p_pfail) else $error("power fail not forced");

  property p_pbo;
    pin.pbo && !pin.pfail && (st_ff != ST_MOFF) && (st_ff != ST_S5) |=> st_ff == ST_S5;
  endproperty
  a_pbo: assert property (p_pbo) else $error("override not forced");

  property p_cv_c1c2;
    (st_ff == ST_C1) ##1 (st_ff == ST_C2) ##[1:50] (st_ff == ST_C1);
  endproperty
  c_cv_c1c2: cover property (p_cv_c1c2);

  property p_cv_c3;
    (st_ff == ST_C3) && !cpu_clock_stop_n;
  endproperty
  c_cv_c3: cover property (p_cv_c3);

  property p_cv_s5wake;
    (st_ff == ST_S5) ##1 (st_ff == ST_C0);
  endproperty
  c_cv_s5wake: cover property (p_cv_s5wake);

endmodule : apt_tracker

//--- tb_acpi_power_state_tracker.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_acpi_power_state_tracker;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  break_event;
  logic        halt_cycle, stop_grant_cycle, power_button_override, power_fail, power_good;
  logic        stop_clock_request_n, cpu_clock_stop_n, cpu_sleep_request_n, halt_cmd, slow;
  logic        clocks_run, mem_self_refresh, main_power_on, boot_required;
  logic [7:0]  ra[4] = '{8'h00, 8'h10, 8'h14, 8'h20};
  logic [31:0] rv[4] = '{32'h0, 32'hFFFF, 32'h4010, 32'h0};
  int          tt[4] = '{1, 1, 3, 4};
  int          n_fail, n_tests, m_st, m_pv, m_c1, m_bt, m_mob, m_cs, i, d, cnt;
  logic [15:0] m_wake;

  assign hready = hreadyout;

  apt_tracker dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .halt_cycle, .stop_grant_cycle, .break_event,
    .power_button_override, .power_fail, .power_good, .stop_clock_request_n,
    .cpu_clock_stop_n, .cpu_sleep_request_n, .clocks_run, .mem_self_refresh,
    .main_power_on, .boot_required);

  apt_cpu_model cpu (.hclk, .hresetn, .stop_clock_request_n, .halt_cmd, .slow,
    .halt_cycle, .stop_grant_cycle);

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 16) begin
      k++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask : rdy

  task bus(input bit w, input logic [7:0] a, input logic [31:0] dat);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    rdy();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : bus

  task st(input int e);
    for (int k = 0; k < 20; k++) begin
      bus(1'b0, 8'h0C, 32'h0);
      if (rd[3:0] === e[3:0]) break;
    end
    `CHK(rd[3:0], e[3:0])
  endtask : st

  task pulse(input logic [7:0] b, input logic h, input logic o);
    break_event           <= b;
    halt_cmd              <= h;
    power_button_override <= o;
    repeat (5) @(posedge hclk);
    break_event           <= 8'h0;
    halt_cmd              <= 1'b0;
    power_button_override <= 1'b0;
    @(posedge hclk);
  endtask : pulse

  // Drive one event, advance the reference model, compare state and pins
  task ev(input string e, input int a);
    case (e)
      "halt": pulse(8'h0, 1'b1, 1'b0);
      "brk": pulse(a[7:0], 1'b0, 1'b0);
      "pbo": pulse(8'h0, 1'b0, 1'b1);
      "l2r": bus(1'b0, 8'h04, 32'h0);
      "l2w": bus(1'b1, 8'h04, 32'h0);
      "l3r": bus(1'b0, 8'h08, 32'h0);
      "slp": bus(1'b1, 8'h00, 32'((m_mob << 6) | (m_cs << 5) | (a << 1) | 1));
      "pf": begin
        power_fail <= 1'b1;
        power_good <= 1'b0;
        repeat (6) @(posedge hclk);
        power_fail <= 1'b0;
      end
      default: begin
        power_good <= 1'b1;
        repeat (6) @(posedge hclk);
      end
    endcase
    case (e)
      "halt": if (m_st == 1) m_st = 2;
      "l2r": if (m_st == 1 || m_st == 2) begin
        m_c1 = (m_st == 2);
        m_st = 3;
      end
      "l2w": if (m_st == 3) m_st = m_c1 ? 2 : 1;
      "l3r": if (m_st == 1 && m_mob == 1) m_st = 4;
      "slp": if (m_st == 1 && a inside {1, 3, 4, 5}) m_st = (a == 1) ? 5 : a + 3;
      "brk": if ((m_st > 1 && m_st < 8 && (a & m_wake[7:0]) != 0) ||
                 (m_st == 8 && (a & m_wake[15:8]) != 0)) begin
        m_bt = m_bt | (m_st == 8);
        m_st = 1;
      end
      "pbo": if (m_st > 0) m_st = 8;
      "pf": begin
        m_pv = m_st;
        m_st = 0;
      end
      default: if (m_st == 0) begin
        m_bt = m_bt | (m_pv != 8);
        m_st = (m_pv == 8) ? 8 : 1;
      end
    endcase
    st(m_st);
    repeat (10) @(posedge hclk);
    `CHK(main_power_on, !(m_st == 0 || m_st > 6))
    `CHK(clocks_run, !(m_st == 0 || m_st > 5 || (m_st == 5 && m_mob == 1)))
    `CHK(boot_required, m_bt[0])
    `CHK(stop_clock_request_n, m_st < 3 || m_st > 5)
    `CHK(cpu_clock_stop_n, !(m_st == 4 || (m_st == 5 && m_mob == 1)))
    `CHK(cpu_sleep_request_n, !(m_st == 5 && m_cs == 1 && m_mob == 0))
    `CHK(mem_self_refresh, m_st == 6 || (m_st == 5 && m_mob == 1))
  endtask : ev

  initial begin
    {hsel, hwrite, halt_cmd, slow, power_button_override, power_fail, power_good} = 7'h0;
    {haddr, hwdata, htrans, break_event} = 74'h0;
    hsize   = 3'h2;
    hresetn = 1'b0;
    {n_fail, n_tests, m_st, m_pv, m_c1, m_bt, m_mob, m_cs} = 256'h0;
    m_wake  = 16'hFFFF;
    d = $urandom(64706);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 4; i++) begin
      bus(1'b0, ra[i], 32'h0);
      `CHK(rd, rv[i])
    end
    $display("test register reset done");
    ev("pg", 0);
    bus(1'b1, 8'h0C, 32'h100);
    m_bt = 0;
    ev("halt", 0);
    ev("brk", 1 << ($urandom % 8));
    slow <= 1'($urandom % 2);
    ev("l2r", 0);
    ev("l2w", 0);
    ev("halt", 0);
    ev("l2r", 0);
    ev("l2w", 0);
    ev("l2r", 0);
    ev("brk", 1 << ($urandom % 8));
    ev("l3r", 0);
    m_mob = 1;
    bus(1'b1, 8'h00, 32'h40);
    ev("l3r", 0);
    ev("brk", 1 << ($urandom % 8));
    $display("test processor states done");
    for (i = 0; i < 4; i++) begin
      m_mob = (i == 1);
      m_cs = (i == 0);
      ev("slp", tt[i]);
      ev("brk", 1 << ($urandom % 8));
    end
    ev("slp", 2);
    $display("test sleep states done");
    m_wake = 16'h01FE;
    bus(1'b1, 8'h10, 32'h01FE);
    ev("slp", 4);
    ev("brk", 1);
    ev("brk", 2);
    ev("slp", 5);
    ev("brk", 2);
    ev("brk", 1);
    $display("test wake sets done");
    ev("halt", 0);
    ev("pbo", 0);
    ev("pf", 0);
    ev("brk", 1);
    ev("pg", 0);
    ev("brk", 1);
    ev("pf", 0);
    ev("pg", 0);
    $display("test power events done");
    d = 1 + $urandom % 15;
    m_mob = 0;
    bus(1'b1, 8'h14, {16'h0, 8'h10, d[7:0]});
    bus(1'b1, 8'h00, 32'h10);
    repeat (8) @(posedge hclk);
    cnt = 0;
    repeat (64) begin
      @(negedge hclk);
      if (stop_clock_request_n === 1'b0) cnt++;
    end
    `CHK(cnt, 4 * d)
    bus(1'b1, 8'h00, 32'h0);
    $display("test throttle done");
    print_verdict();
  end
endmodule : tb_acpi_power_state_tracker
